// [pcs_pkg.sv]
/*
 Package for the program counter and stack unit: widths, vectors,
 memory sizes, operation codes and the carrier structs.
 Assumes a single core clock and a synchronous reset.
*/
package pcs_pkg;
	localparam int PC_W = 15;
	localparam int INSN_W = 14;
	localparam int STK_DEPTH = 16;
	localparam int STK_PTR_W = 5;
	localparam int FP_W = 16;
	localparam int DATA_W = 8;
	localparam int NUM_INSN = 49;
	localparam logic [14:0] RESET_VEC = 15'h0000;
	localparam logic [14:0] INT_VEC = 15'h0004;
	localparam logic [14:0] LAST_ADDR_SMALL = 15'h0FFF;
	localparam logic [14:0] LAST_ADDR_LARGE = 15'h1FFF;
	localparam logic [15:0] FP_PROG_BIT = 16'h8000;
	localparam logic [15:0] FP_RESET = 16'h0000;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [4:0] PTR_RESET = 5'h00;
	localparam int GPR_PER_BANK = 80;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_CALL = 4'h1,
		OP_GOTO = 4'h2,
		OP_RETURN = 4'h3,
		OP_RET_LIT = 4'h4,
		OP_RETFIE = 4'h5,
		OP_BRANCH_ACC = 4'h6,
		OP_FP_LOAD = 4'h7,
		OP_FP_READ = 4'h8
	} pcs_op_e;

	typedef struct packed {
		pcs_op_e op;
		logic fp_sel;
		logic [14:0] target;
		logic [15:0] fp_value;
		logic [7:0] literal;
	} pcs_cmd_s;

	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] status;
		logic [7:0] bank_sel;
		logic [7:0] pc_latch;
	} pcs_ctx_s;
endpackage

// [pcs_core.sv]
/*
 Program counter, return stack, shadow context and file pointers.
 Assumes the decoder issues one command per cycle with cmd_valid and
 waits while stall is high; program memory answers in the same cycle.
*/
// Functional notes
// - Program counter is 15 bits, addressing up to 32K words of 14 bits.
// - Addresses above implemented memory wrap inside it.
// - Fetch starts at 0000h after reset; interrupts vector to 0004h.
// - Memory is 4096 words (0FFFh) small, 8192 words (1FFFh) large.
// - Return stack is 15 bits wide and 16 entries deep.
// - Push on full sets overflow flag; pop on empty sets underflow.
// - With stack reset enabled, either error requests a software reset.
// - Interrupt entry saves core registers to shadows; RETFIE restores them.
// - Two 16-bit file pointers reach data and program memory.
// - Indirect read of program memory takes one extra cycle.
// - File pointer 0 drives linear_addr directly; file pointer 1 has no linear output.
// - Decoder supports a set of 49 instructions.
`timescale 1ns/1ps
module pcs_core
	import pcs_pkg::*;
#(
	parameter bit LARGE_MEM = 1'b1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic cmd_valid,
	input wire pcs_cmd_s cmd,
	input wire logic int_take,
	input wire pcs_ctx_s ctx_in,
	input wire logic stk_rst_en,
	input wire logic flag_clr,
	input wire logic [13:0] prog_rdata,
	output logic [14:0] prog_addr,
	output logic [14:0] pc,
	output logic [7:0] acc_load,
	output logic acc_load_valid,
	output logic [7:0] fp_rdata,
	output logic fp_rdata_valid,
	output logic stall,
	output pcs_ctx_s ctx_out,
	output logic ctx_restore,
	output logic stack_overflow_flag,
	output logic stack_underflow_flag,
	output logic soft_reset,
	output logic [15:0] file_pointer0,
	output logic [15:0] file_pointer1,
	output logic [15:0] linear_addr
);
	typedef enum logic [0:0] {
		ST_RUN = 1'b0,
		ST_PMR = 1'b1
	} pcs_state_e;

	localparam logic [14:0] ADDR_MASK = LARGE_MEM ? LAST_ADDR_LARGE : LAST_ADDR_SMALL;

	logic [14:0] stack_mem [STK_DEPTH];
	logic [14:0] pc_ff, nxt_pc;
	logic [4:0] sp_ff, nxt_sp;
	logic ovf_ff, nxt_ovf, unf_ff, nxt_unf, srst_ff, nxt_srst;
	logic [15:0] fp_ff [2];
	logic [15:0] nxt_fp [2];
	pcs_ctx_s shadow_ff, nxt_shadow;
	pcs_state_e state_ff, nxt_state;
	logic [14:0] pmr_addr_ff, nxt_pmr_addr;
	logic [7:0] acc_ff, nxt_acc;
	logic acc_v_ff, nxt_acc_v, rd_v_ff, nxt_rd_v, rest_ff, nxt_rest;
	logic [7:0] rd_ff, nxt_rd;
	logic push, pop;
	logic [14:0] push_val, top;
	logic [15:0] sel_fp;

	assign top = (sp_ff == PTR_RESET) ? RESET_VEC : stack_mem[4'(sp_ff - 5'd1)];
	assign sel_fp = fp_ff[cmd.fp_sel];

	always_comb begin
		nxt_pc = pc_ff;
		nxt_sp = sp_ff;
		nxt_ovf = flag_clr ? 1'b0 : ovf_ff;
		nxt_unf = flag_clr ? 1'b0 : unf_ff;
		nxt_srst = 1'b0;
		nxt_fp = fp_ff;
		nxt_shadow = shadow_ff;
		nxt_state = state_ff;
		nxt_pmr_addr = pmr_addr_ff;
		nxt_acc = acc_ff;
		nxt_acc_v = 1'b0;
		nxt_rd = rd_ff;
		nxt_rd_v = 1'b0;
		nxt_rest = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		push_val = pc_ff;
		unique case (state_ff)
			ST_RUN: begin
				if (int_take) begin
					push = 1'b1;
					push_val = pc_ff;
					nxt_pc = INT_VEC;
					nxt_shadow = ctx_in;
				end else if (cmd_valid) begin
					nxt_pc = pc_ff + 15'd1;
					unique case (cmd.op)
						OP_CALL: begin
							push = 1'b1;
							push_val = pc_ff + 15'd1;
							nxt_pc = cmd.target;
						end
						OP_GOTO: nxt_pc = cmd.target;
						OP_RETURN: begin
							pop = 1'b1;
							nxt_pc = top;
						end
						OP_RET_LIT: begin
							pop = 1'b1;
							nxt_pc = top;
							nxt_acc = cmd.literal;
							nxt_acc_v = 1'b1;
						end
						OP_RETFIE: begin
							pop = 1'b1;
							nxt_pc = top;
							nxt_rest = 1'b1;
						end
						OP_BRANCH_ACC: nxt_pc = pc_ff + 15'd1 + {7'h00, ctx_in.acc};
						OP_FP_LOAD: nxt_fp[cmd.fp_sel] = cmd.fp_value;
						OP_FP_READ: begin
							if ((sel_fp & FP_PROG_BIT) != FP_RESET) begin
								nxt_pc = pc_ff;
								nxt_state = ST_PMR;
								nxt_pmr_addr = sel_fp[14:0];
							end
						end
						default: ;
					endcase
				end
			end
			ST_PMR: begin
				nxt_rd = prog_rdata[7:0];
				nxt_rd_v = 1'b1;
				nxt_pc = pc_ff + 15'd1;
				nxt_state = ST_RUN;
			end
		endcase
		if (push) begin
			if (sp_ff == 5'(STK_DEPTH)) begin
				nxt_ovf = 1'b1;
				nxt_srst = stk_rst_en;
			end else begin
				nxt_sp = sp_ff + 5'd1;
			end
		end
		if (pop) begin
			if (sp_ff == PTR_RESET) begin
				nxt_unf = 1'b1;
				nxt_srst = stk_rst_en;
			end else begin
				nxt_sp = sp_ff - 5'd1;
			end
		end
		nxt_pc = nxt_pc & ADDR_MASK;
		nxt_pmr_addr = nxt_pmr_addr & ADDR_MASK;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pc_ff <= RESET_VEC;
			sp_ff <= PTR_RESET;
			ovf_ff <= 1'b0;
			unf_ff <= 1'b0;
			srst_ff <= 1'b0;
			fp_ff[0] <= FP_RESET;
			fp_ff[1] <= FP_RESET;
			shadow_ff <= '0;
			state_ff <= ST_RUN;
			pmr_addr_ff <= RESET_VEC;
			acc_ff <= ACC_RESET;
			acc_v_ff <= 1'b0;
			rd_ff <= ACC_RESET;
			rd_v_ff <= 1'b0;
			rest_ff <= 1'b0;
		end else if (ce) begin
			pc_ff <= nxt_pc;
			sp_ff <= nxt_sp;
			ovf_ff <= nxt_ovf;
			unf_ff <= nxt_unf;
			srst_ff <= nxt_srst;
			fp_ff <= nxt_fp;
			shadow_ff <= nxt_shadow;
			state_ff <= nxt_state;
			pmr_addr_ff <= nxt_pmr_addr;
			acc_ff <= nxt_acc;
			acc_v_ff <= nxt_acc_v;
			rd_ff <= nxt_rd;
			rd_v_ff <= nxt_rd_v;
			rest_ff <= nxt_rest;
		end
	end

	always_ff @(posedge mclk) begin
		if (ce && push && sp_ff != 5'(STK_DEPTH)) begin
			stack_mem[4'(sp_ff)] <= push_val;
		end
	end

	assign linear_addr = fp_ff[0];
	assign file_pointer0 = fp_ff[0];
	assign file_pointer1 = fp_ff[1];
	assign prog_addr = (state_ff == ST_PMR) ? pmr_addr_ff : pc_ff;
	assign pc = pc_ff;
	assign stall = (state_ff == ST_PMR);
	assign acc_load = acc_ff;
	assign acc_load_valid = acc_v_ff;
	assign fp_rdata = rd_ff;
	assign fp_rdata_valid = rd_v_ff;
	assign ctx_out = shadow_ff;
	assign ctx_restore = rest_ff;
	assign stack_overflow_flag = ovf_ff;
	assign stack_underflow_flag = unf_ff;
	assign soft_reset = srst_ff;

	a_pc_wrap_mask: assert property (@(posedge mclk) disable iff (rst)
		(pc_ff & ~ADDR_MASK) == 15'h0000) else $error("pc outside memory");
	a_int_vector_taken: assert property (@(posedge mclk) disable iff (rst)
		ce && int_take && state_ff == ST_RUN |=> pc_ff == INT_VEC) else $error("bad int vector");
	a_ovf_on_full: assert property (@(posedge mclk) disable iff (rst)
		ce && push && sp_ff == 5'(STK_DEPTH) |=> ovf_ff) else $error("overflow lost");
	a_unf_on_empty: assert property (@(posedge mclk) disable iff (rst)
		ce && pop && sp_ff == PTR_RESET |=> unf_ff) else $error("underflow lost");
	a_sp_bound_depth: assert property (@(posedge mclk) disable iff (rst)
		sp_ff <= 5'(STK_DEPTH)) else $error("stack pointer out of range");
	a_srst_on_error: assert property (@(posedge mclk) disable iff (rst)
		ce && stk_rst_en && ((push && sp_ff == 5'(STK_DEPTH)) || (pop && sp_ff == PTR_RESET))
		|=> soft_reset) else $error("no soft reset");
	a_pmr_extra_cycle: assert property (@(posedge mclk) disable iff (rst)
		ce && state_ff == ST_PMR |=> !stall && fp_rdata_valid) else $error("read not one cycle");
	a_ret_lit_acc: assert property (@(posedge mclk) disable iff (rst)
		ce && cmd_valid && !int_take && state_ff == ST_RUN && cmd.op == OP_RET_LIT
		|=> acc_load_valid && acc_load == $past(cmd.literal)) else $error("literal missing");
	a_shadow_saved_int: assert property (@(posedge mclk) disable iff (rst)
		ce && int_take && state_ff == ST_RUN |=> ctx_out == $past(ctx_in)) else $error("no shadow");
	a_srst_gated_off: assert property (@(posedge mclk) disable iff (rst)
		ce && !stk_rst_en |=> !soft_reset) else $error("soft reset while disabled");
	a_ovf_clear_works: assert property (@(posedge mclk) disable iff (rst)
		ce && flag_clr && !push |=> !stack_overflow_flag) else $error("overflow not cleared");
	a_unf_clear_works: assert property (@(posedge mclk) disable iff (rst)
		ce && flag_clr && !pop |=> !stack_underflow_flag) else $error("underflow not cleared");
	a_sp_push_step: assert property (@(posedge mclk) disable iff (rst)
		ce && push && sp_ff != 5'(STK_DEPTH) |=> sp_ff == 5'($past(sp_ff) + 5'd1))
		else $error("push did not advance");
	a_reset_vector: assert property (@(posedge mclk)
		rst |=> pc == RESET_VEC && !stall && !soft_reset) else $error("bad reset state");
	a_pc_step_one: assert property (@(posedge mclk) disable iff (rst)
		ce && cmd_valid && !int_take && state_ff == ST_RUN && cmd.op inside {OP_NONE, OP_FP_LOAD}
		|=> pc == 15'(($past(pc) + 15'd1) & ADDR_MASK)) else $error("pc did not step");
	a_pmr_addr_wrap: assert property (@(posedge mclk) disable iff (rst)
		stall |-> (prog_addr & ~ADDR_MASK) == 15'h0000) else $error("read outside memory");
	a_branch_acc_adds: assert property (@(posedge mclk) disable iff (rst)
		ce && cmd_valid && !int_take && state_ff == ST_RUN && cmd.op == OP_BRANCH_ACC
		|=> pc == 15'(($past(pc_ff) + 15'd1 + {7'h00, $past(ctx_in.acc)}) & ADDR_MASK))
		else $error("branch target wrong");
	a_fp_load_sel: assert property (@(posedge mclk) disable iff (rst)
		ce && cmd_valid && !int_take && state_ff == ST_RUN && cmd.op == OP_FP_LOAD
		|=> ($past(cmd.fp_sel) ? file_pointer1 : file_pointer0) == $past(cmd.fp_value))
		else $error("pointer not loaded");
	a_retfie_restore: assert property (@(posedge mclk) disable iff (rst)
		ce && cmd_valid && !int_take && state_ff == ST_RUN && cmd.op == OP_RETFIE
		|=> ctx_restore) else $error("no context restore");
	a_ce_freeze: assert property (@(posedge mclk) disable iff (rst)
		!ce |=> pc_ff == $past(pc_ff) && sp_ff == $past(sp_ff)) else $error("state moved");

	sequence s_pmr_req;
		ce && cmd_valid && !int_take && state_ff == ST_RUN
			&& cmd.op == OP_FP_READ && sel_fp[15];
	endsequence
	sequence s_pmr_hold;
		stall && ce;
	endsequence
	sequence s_pmr_done;
		!stall && fp_rdata_valid;
	endsequence
	a_pmr_read_steps: assert property (@(posedge mclk) disable iff (rst)
		s_pmr_req ##1 s_pmr_hold |=> s_pmr_done) else $error("pointer read not two cycles");
	a_pmr_addr_taken: assert property (@(posedge mclk) disable iff (rst)
		s_pmr_req |=> stall && prog_addr == (15'($past(sel_fp)) & ADDR_MASK))
		else $error("pointer read address wrong");
endmodule

// [pcs_prog_mem.sv]
/*
 Program memory model answering prog_addr at once.
 Assumes a combinational read path in the core.
*/
`timescale 1ns/1ps
module pcs_prog_mem (
	input wire logic [14:0] prog_addr,
	output logic [13:0] prog_rdata
);
	assign prog_rdata = {prog_addr[5:0], ~prog_addr[7:0]};
endmodule

// [test_program_counter_stack_unit.sv]
/*
 Self-checking bench for the core, large and small memory variants.
 Assumes pcs_pkg and pcs_prog_mem are compiled first.
*/
`timescale 1ns/1ps
module test_program_counter_stack_unit import pcs_pkg::*;;
	logic mclk = 0, rst = 1, ce = 1, cmd_valid = 0, int_take = 0;
	logic stk_rst_en = 0, flag_clr = 0;
	pcs_cmd_s cmd = '0;
	pcs_ctx_s ctx_in = '0;
	logic [14:0] prog_addr, pc;
	logic [13:0] prog_rdata;
	logic [7:0] acc_load, fp_rdata;
	logic acc_load_valid, fp_rdata_valid, stall, ctx_restore;
	logic ovf, unf, soft_reset;
	pcs_ctx_s ctx_out;
	logic [15:0] fp0, fp1, lin;
	int fail_count = 0;
	int check_count = 0;
	always #20 mclk = ~mclk;
	pcs_core #(.LARGE_MEM(1'b1)) uut (.mclk(mclk), .rst(rst), .ce(ce),
		.cmd_valid(cmd_valid), .cmd(cmd), .int_take(int_take), .ctx_in(ctx_in),
		.stk_rst_en(stk_rst_en), .flag_clr(flag_clr), .prog_rdata(prog_rdata),
		.prog_addr(prog_addr), .pc(pc), .acc_load(acc_load),
		.acc_load_valid(acc_load_valid), .fp_rdata(fp_rdata),
		.fp_rdata_valid(fp_rdata_valid), .stall(stall), .ctx_out(ctx_out),
		.ctx_restore(ctx_restore), .stack_overflow_flag(ovf),
		.stack_underflow_flag(unf), .soft_reset(soft_reset),
		.file_pointer0(fp0), .file_pointer1(fp1), .linear_addr(lin));
	pcs_prog_mem mem (.prog_addr(prog_addr), .prog_rdata(prog_rdata));
	logic [14:0] prog_addr_s, pc_s;
	logic [13:0] prog_rdata_s;
	pcs_core #(.LARGE_MEM(1'b0)) uut_small (.mclk(mclk), .rst(rst), .ce(ce),
		.cmd_valid(cmd_valid), .cmd(cmd), .int_take(int_take), .ctx_in(ctx_in),
		.stk_rst_en(stk_rst_en), .flag_clr(flag_clr), .prog_rdata(prog_rdata_s),
		.prog_addr(prog_addr_s), .pc(pc_s), .acc_load(), .acc_load_valid(), .fp_rdata(),
		.fp_rdata_valid(), .stall(), .ctx_out(), .ctx_restore(), .stack_overflow_flag(),
		.stack_underflow_flag(), .soft_reset(), .file_pointer0(), .file_pointer1(),
		.linear_addr());
	pcs_prog_mem mem_small (.prog_addr(prog_addr_s), .prog_rdata(prog_rdata_s));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic op(input pcs_op_e o, input logic [14:0] t, input logic [15:0] v,
		input logic [7:0] l);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd <= '{o, 1'b0, t, v, l};
		@(posedge mclk);
		cmd_valid <= 1'b0;
		#1;
	endtask
	task automatic pulse_in(input bit is_int);
		@(posedge mclk);
		if (is_int) int_take <= 1'b1;
		else flag_clr <= 1'b1;
		@(posedge mclk);
		int_take <= 1'b0;
		flag_clr <= 1'b0;
		#1;
	endtask
	task automatic t_reset();
		chk("pc", RESET_VEC, pc);
		chk("flags", 0, {ovf, unf, stall});
		$display("test reset done");
	endtask
	task automatic t_wrap();
		op(OP_GOTO, 15'h7ABC, 0, 0);
		chk("pc", 15'h1ABC, pc);
		chk("prog_addr", 15'h1ABC, prog_addr);
		chk("pc small", 15'h0ABC, pc_s);
		$display("test wrap done");
	endtask
	task automatic t_int();
		ctx_in <= '{8'h03, 8'h1A, 8'h05, 8'h02};
		op(OP_GOTO, 15'h0123, 0, 0);
		pulse_in(1);
		chk("pc", INT_VEC, pc);
		chk("ctx_out", 32'h031A0502, ctx_out);
		op(OP_RETFIE, 0, 0, 0);
		chk("pc", 15'h0123, pc);
		chk("ctx_restore", 1, ctx_restore);
		$display("test interrupt done");
	endtask
	task automatic t_table();
		op(OP_CALL, 15'h0200, 0, 0);
		chk("pc", 15'h0200, pc);
		op(OP_BRANCH_ACC, 0, 0, 0);
		chk("pc", 15'h0204, pc);
		op(OP_RET_LIT, 0, 0, 8'hA5);
		chk("acc", 9'h1A5, {acc_load_valid, acc_load});
		$display("test table done");
	endtask
	task automatic t_stack();
		stk_rst_en <= 1'b1;
		for (int i = 0; i < 16; i++) op(OP_CALL, 15'h0300, 0, 0);
		chk("ovf", 0, ovf);
		op(OP_CALL, 15'h0300, 0, 0);
		chk("ovf", 1, ovf);
		chk("soft_reset", 1, soft_reset);
		stk_rst_en <= 1'b0;
		pulse_in(0);
		chk("ovf", 0, ovf);
		for (int i = 0; i < 16; i++) op(OP_RETURN, 0, 0, 0);
		chk("unf", 0, unf);
		op(OP_RETURN, 0, 0, 0);
		chk("unf pc", 16'h8000, {unf, pc});
		chk("soft_reset", 0, soft_reset);
		$display("test stack done");
	endtask
	task automatic t_fp();
		op(OP_FP_LOAD, 0, 16'h8100, 0);
		chk("fp0", 16'h8100, fp0);
		chk("linear", 16'h8100, lin);
		op(OP_FP_READ, 0, 0, 0);
		chk("stall", 16'h8100, {stall, prog_addr});
		@(posedge mclk);
		#1;
		chk("fp_rdata", 9'h1FF, {fp_rdata_valid, fp_rdata});
		chk("pc after read", 15'h0002, pc);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd <= '{OP_FP_LOAD, 1'b1, 15'h0000, 16'h0123, 8'h00};
		@(posedge mclk);
		cmd_valid <= 1'b0;
		#1;
		chk("fp1", 16'h0123, fp1);
		chk("fp0 kept", 16'h8100, fp0);
		$display("test pointer done");
	endtask
	task automatic t_ce();
		@(posedge mclk);
		ce <= 1'b0;
		cmd_valid <= 1'b1;
		cmd <= '{OP_GOTO, 1'b0, 15'h0055, 16'h0000, 8'h00};
		@(posedge mclk);
		ce <= 1'b1;
		cmd_valid <= 1'b0;
		#1;
		chk("pc frozen", 15'h0003, pc);
		$display("test enable done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		#1;
		t_reset();
		t_wrap();
		t_int();
		t_table();
		t_stack();
		t_fp();
		t_ce();
		report_and_stop();
	end
	initial begin
		#100000;
		fail_count++;
		report_and_stop();
	end
endmodule
